// *** src/asc_pkg.sv ***
// Constants and types for the conversion sequence controller
// ============================================================
// How it works
// - Every conversion yields one 8-bit result byte
// - One conversion takes 32 E clock cycles
// - Below 750 kHz use internal R-C clock
// - Low reference gives 00, high gives FF
// - Sequence starts one cycle after control write
// - Multiplexer picks one of sixteen sources
// - Single one-shot: four results, then halt
// - Single continuous: fifth result overwrites first
// - Group one-shot: each channel once, then stop
// - Group continuous: passes replace same-channel results
// - Low-power entry suspends; exit resamples, resumes
// - Control bits writable; bit 7 status, 6 zero
// - Done flag sets when four results valid
// - Control write clears flag, restarts sequence
// - Continuous modes keep done flag set
// - Single mode converts channel in bits 3:0
// - Group mode: high bits group, low bits slot
// - Channel code map: ports, references, reserved
// - Sample switch closed first 12 cycles only
// - Result registers are read-only
// - First result valid 33 cycles after write
// - Clock-select bit picks E or R-C clock
// - Converter powered only while power bit set
`default_nettype none
package asc_pkg;
   // ===================== Register map =====================
   localparam logic [2:0] ASC_OFS_CTRL = 3'h0;
   localparam logic [2:0] ASC_OFS_RES1 = 3'h1;
   localparam logic [2:0] ASC_OFS_RES2 = 3'h2;
   localparam logic [2:0] ASC_OFS_RES3 = 3'h3;
   localparam logic [2:0] ASC_OFS_RES4 = 3'h4;
   localparam logic [2:0] ASC_OFS_OPT = 3'h5;
   localparam int ASC_AW = 3;
   localparam int ASC_DW = 8;
   // ===================== Field positions ==================
   localparam int ASC_BIT_DONE = 7;
   localparam int ASC_BIT_ZERO = 6;
   localparam int ASC_BIT_SCAN = 5;
   localparam int ASC_BIT_GROUP = 4;
   localparam int ASC_BIT_PWR = 7;
   localparam int ASC_BIT_CONV_CLOCK_SOURCE = 6;
   localparam int ASC_BIT_WAKE = 4;
   localparam logic [7:0] ASC_CTRL_RST = 8'h00;
   localparam logic [7:0] ASC_OPT_RST = 8'h10;
   localparam logic [7:0] ASC_RES_RST = 8'h00;
   // ===================== Timing ===========================
   localparam int ASC_CONV_CYC = 32;
   localparam int ASC_SAMPLE_CYC = 12;
   localparam int ASC_START_DLY = 1;
   // ===================== Channel codes ====================
   localparam logic [3:0] ASC_CH_VRH = 4'hC;
   localparam logic [3:0] ASC_CH_VRL = 4'hD;
   localparam logic [3:0] ASC_CH_HALF = 4'hE;
   localparam logic [7:0] ASC_CODE_LO = 8'h00;
   localparam logic [7:0] ASC_CODE_HI = 8'hFF;
   localparam logic [7:0] ASC_CODE_HALF = 8'h80;
   typedef enum logic [3:0] {
      ASC_IDLE = 4'b0001,
      ASC_LAUNCH = 4'b0010,
      ASC_CONV = 4'b0100,
      ASC_HOLD = 4'b1000
   } asc_state_t;
endpackage
`default_nettype wire

// *** src/asc_adc_sequence_controller.sv ***
// Sequencing and register logic of the 8-bit A/D converter
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module asc_adc_sequence_controller #(
   parameter int NUM_PORT = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port
   input wire logic [asc_pkg::ASC_AW-1:0] reg_addr,
   input wire logic [asc_pkg::ASC_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [asc_pkg::ASC_DW-1:0] reg_rdata,
   // Low-power mode indication from the core
   input wire logic low_power_mode,
   // Internal R-C clock tick, one cycle pulse per R-C period
   input wire logic rc_clk_tick,
   // Comparator answer of the successive-approximation array
   input wire logic sar_cmp,
   // Analog front end control
   output logic [3:0] mux_sel,
   output logic sample_switch,
   output logic [7:0] sar_trial,
   output logic converter_power_on,
   output logic conv_clock_source,
   output logic sequence_done_flag
);
   import asc_pkg::*;

   // ===================== Registers ========================
   logic [7:0] ctrl_r;
   logic [7:0] opt_r;
   logic [7:0] result_r [4];
   logic done_r;
   asc_state_t state_r;
   logic [4:0] cyc_r;
   logic [1:0] slot_r;
   logic [7:0] sar_r;
   logic [2:0] bit_r;
   logic [3:0] mux_r;
   logic samp_r;
   logic pwr_r;
   logic conv_clock_source_r;
   logic [7:0] rdata_r;

   wire logic wr_ctrl = reg_wr && reg_addr == ASC_OFS_CTRL;
   wire logic wr_opt = reg_wr && reg_addr == ASC_OFS_OPT;
   wire logic scan_mode = ctrl_r[ASC_BIT_SCAN];

   // Converter clock step: E clock every cycle or R-C tick
   wire logic step = opt_r[ASC_BIT_CONV_CLOCK_SOURCE] ? rc_clk_tick : 1'b1;

   // Channel for a slot: group mode uses high bits and slot index
   function automatic logic [3:0] chan_of(input logic [7:0] c,
                                          input logic [1:0] s);
      chan_of = c[ASC_BIT_GROUP] ? {c[3:2], s} : c[3:0];
   endfunction

   // Internal reference points give fixed codes; ports use the array
   function automatic logic fixed_ch(input logic [3:0] ch);
      fixed_ch = ch == ASC_CH_VRH || ch == ASC_CH_VRL || ch == ASC_CH_HALF;
   endfunction

   function automatic logic [7:0] fixed_code(input logic [3:0] ch);
      unique case (ch)
         ASC_CH_VRH: fixed_code = ASC_CODE_HI;
         ASC_CH_VRL: fixed_code = ASC_CODE_LO;
         default: fixed_code = ASC_CODE_HALF;
      endcase
   endfunction

   // ===================== Control register =================
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= ASC_CTRL_RST;
      end else if (wr_ctrl) begin
         // Bit 7 is status and bit 6 is unimplemented
         ctrl_r <= {2'b00, reg_wdata[5:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         opt_r <= ASC_OPT_RST;
      end else if (wr_opt) begin
         opt_r <= reg_wdata;
      end
   end

   // ===================== Sequencer ========================
   // A control write always wins: it aborts whatever runs
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ASC_IDLE;
         cyc_r <= 5'h00;
         slot_r <= 2'h0;
      end else if (wr_ctrl) begin
         state_r <= ASC_LAUNCH;
         cyc_r <= 5'h00;
         slot_r <= 2'h0;
      end else if (!opt_r[ASC_BIT_PWR]) begin
         state_r <= ASC_IDLE;
         cyc_r <= 5'h00;
      end else begin
         unique case (state_r)
            ASC_IDLE: begin
               state_r <= ASC_IDLE;
            end
            ASC_LAUNCH: begin
               state_r <= ASC_CONV;
               cyc_r <= 5'h00;
            end
            ASC_CONV: begin
               if (low_power_mode) begin
                  state_r <= ASC_HOLD;
               end else if (step) begin
                  if (cyc_r == 5'(ASC_CONV_CYC - 1)) begin
                     cyc_r <= 5'h00;
                     slot_r <= slot_r + 2'h1;
                     if (slot_r == 2'h3 && !scan_mode) begin
                        state_r <= ASC_IDLE;
                     end
                  end else begin
                     cyc_r <= cyc_r + 5'h01;
                  end
               end
            end
            ASC_HOLD: begin
               // Restart the channel from its sample window on exit
               if (!low_power_mode) begin
                  state_r <= ASC_CONV;
                  cyc_r <= 5'h00;
               end
            end
         endcase
      end
   end

   // Launch cycle plus 32 steps puts the first result at cycle 33
   wire logic conv_end = state_r == ASC_CONV && !low_power_mode
      && step && cyc_r == 5'(ASC_CONV_CYC - 1) && !wr_ctrl
      && opt_r[ASC_BIT_PWR];

   // ===================== Successive approximation =========
   // Bits are trialled after the sample window, MSB first
   wire logic [3:0] cur_ch = chan_of(ctrl_r, slot_r);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sar_r <= 8'h00;
         bit_r <= 3'h7;
      end else if (state_r != ASC_CONV || cyc_r < 5'(ASC_SAMPLE_CYC)) begin
         sar_r <= 8'h80;
         bit_r <= 3'h7;
      end else if (step && cyc_r >= 5'(ASC_SAMPLE_CYC + 1)
                   && cyc_r <= 5'(ASC_SAMPLE_CYC + 8)) begin
         sar_r[bit_r] <= sar_cmp;
         if (bit_r != 3'h0) begin
            sar_r[bit_r - 3'h1] <= 1'b1;
            bit_r <= bit_r - 3'h1;
         end
      end
   end

   // ===================== Results and done flag ============
   // Results only come from the converter; writes are ignored
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) begin
            result_r[i] <= ASC_RES_RST;
         end
      end else if (conv_end) begin
         if (fixed_ch(cur_ch)) begin
            result_r[slot_r] <= fixed_code(cur_ch);
         end else begin
            result_r[slot_r] <= sar_r;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         done_r <= 1'b0;
      end else if (wr_ctrl) begin
         done_r <= 1'b0;
      end else if (conv_end && slot_r == 2'h3) begin
         done_r <= 1'b1;
      end
   end

   // ===================== Front end outputs ================
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mux_r <= 4'h0;
         samp_r <= 1'b0;
         pwr_r <= 1'b0;
         conv_clock_source_r <= 1'b0;
      end else begin
         mux_r <= cur_ch;
         samp_r <= state_r == ASC_CONV && !low_power_mode
            && cyc_r < 5'(ASC_SAMPLE_CYC);
         pwr_r <= opt_r[ASC_BIT_PWR];
         conv_clock_source_r <= opt_r[ASC_BIT_CONV_CLOCK_SOURCE];
      end
   end

   // ===================== Read port ========================
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ASC_OFS_CTRL: rdata_r <= {done_r, 1'b0, ctrl_r[5:0]};
            ASC_OFS_RES1: rdata_r <= result_r[0];
            ASC_OFS_RES2: rdata_r <= result_r[1];
            ASC_OFS_RES3: rdata_r <= result_r[2];
            ASC_OFS_RES4: rdata_r <= result_r[3];
            ASC_OFS_OPT: rdata_r <= opt_r;
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;
   assign mux_sel = mux_r;
   assign sample_switch = samp_r;
   assign sar_trial = sar_r;
   assign converter_power_on = pwr_r;
   assign conv_clock_source = conv_clock_source_r;
   assign sequence_done_flag = done_r;
endmodule // asc_adc_sequence_controller
`default_nettype wire

// *** verification/asc_sar_model.sv ***
// Behavioural analog sources and comparator for the converter
`timescale 1ns/100ps
`default_nettype none
module asc_sar_model (
   // Converter side
   input wire logic [3:0] mux_sel,
   input wire logic [7:0] sar_trial,
   output logic sar_cmp
);
   // ============================================================
   // Channel levels
   // Channel n sits at {n, ~n} so that a wrong select shows up
   assign sar_cmp = ({mux_sel, ~mux_sel} >= sar_trial);
endmodule // asc_sar_model
`default_nettype wire

// *** verification/asc_adc_sequence_controller_assertions.sv ***
// Port checker of the conversion sequence controller
`timescale 1ns/100ps
`default_nettype none
module asc_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port
   input wire logic [asc_pkg::ASC_AW-1:0] reg_addr,
   input wire logic [asc_pkg::ASC_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [asc_pkg::ASC_DW-1:0] reg_rdata,
   // Converter side
   input wire logic low_power_mode,
   input wire logic [3:0] mux_sel,
   input wire logic sample_switch,
   input wire logic converter_power_on,
   input wire logic conv_clock_source,
   input wire logic sequence_done_flag
);
   import asc_pkg::*;
   // ============================================================
   // Helper state
   logic wr_c, rd_c, opt_w, slow_r;
   logic [4:0] hi_r;
   logic [8:0] cyc_r;
   logic [7:0] opt_r, ctl_r;
   assign wr_c = reg_wr && reg_addr == ASC_OFS_CTRL;
   assign rd_c = reg_rd && reg_addr == ASC_OFS_CTRL;
   assign opt_w = reg_wr && reg_addr == ASC_OFS_OPT;
   // Timing checks hold only for an E clock run left undisturbed
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hi_r <= 5'h00;
         cyc_r <= 9'h000;
         slow_r <= 1'b1;
      end else begin
         hi_r <= sample_switch ? hi_r + 5'h01 : 5'h00;
         cyc_r <= wr_c ? 9'h000 : cyc_r + 9'h001;
         slow_r <= !wr_c && (slow_r || reg_wr || low_power_mode ||
            conv_clock_source || !converter_power_on);
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         opt_r <= ASC_OPT_RST;
         ctl_r <= ASC_CTRL_RST;
      end else if (opt_w) begin
         opt_r <= reg_wdata;
      end else if (wr_c) begin
         ctl_r <= reg_wdata;
      end
   end
   // ============================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence s_go;
      wr_c && converter_power_on && !conv_clock_source && !low_power_mode;
   endsequence
   sequence s_sample;
      ##[1:4] $rose(sample_switch);
   endsequence
   property p_start; s_go |-> s_sample; endproperty
   a_start: assert property (p_start)
      else $error("no sample start");
   property p_clr; wr_c |=> !sequence_done_flag; endproperty
   a_clr: assert property (p_clr)
      else $error("done not cleared");
   property p_sample; $fell(sample_switch) && !slow_r |-> hi_r == 5'h0C;
   endproperty
   a_sample: assert property (p_sample)
      else $error("bad sample");
   property p_done; $rose(sequence_done_flag) && !slow_r |-> cyc_r == 9'h081;
   endproperty
   a_done: assert property (p_done)
      else $error("done late");
   property p_mux; sample_switch && !slow_r && cyc_r > 9'h002 |->
      mux_sel[3:2] == ctl_r[3:2] &&
      (ctl_r[ASC_BIT_GROUP] || mux_sel[1:0] == ctl_r[1:0]); endproperty
   a_mux: assert property (p_mux)
      else $error("bad channel");
   property p_one; sequence_done_flag && !ctl_r[ASC_BIT_SCAN] |->
      !sample_switch; endproperty
   a_one: assert property (p_one)
      else $error("runs after stop");
   property p_hold; sequence_done_flag && converter_power_on && !reg_wr &&
      !$past(reg_wr) && !$past(reg_wr, 2) |=> sequence_done_flag;
   endproperty
   a_hold: assert property (p_hold)
      else $error("done dropped");
   property p_opt; opt_w |-> ##2
      {converter_power_on, conv_clock_source} == opt_r[7:6]; endproperty
   a_opt: assert property (p_opt)
      else $error("option copy");
   property p_zero; $past(rd_c) |->
      reg_rdata[7:6] == {$past(sequence_done_flag), 1'b0}; endproperty
   a_zero: assert property (p_zero)
      else $error("bad status");
endmodule // asc_checker
bind asc_adc_sequence_controller asc_checker asc_checker_inst (
   .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .low_power_mode(low_power_mode),
   .mux_sel(mux_sel), .sample_switch(sample_switch),
   .converter_power_on(converter_power_on),
   .conv_clock_source(conv_clock_source),
   .sequence_done_flag(sequence_done_flag));
`default_nettype wire

// *** verification/tb_adc_sequence_controller.sv ***
// Register-level testbench of the conversion sequence controller
`timescale 1ns/100ps
`default_nettype none
module tb_adc_sequence_controller;
   import asc_pkg::*;
   // ============================================================
   // Stimulus and design
   logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic low_power_mode = 1'b0, rc_clk_tick = 1'b0;
   logic [2:0] reg_addr = 3'h0, rc_cnt = 3'h0, g;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, sar_trial;
   logic [3:0] mux_sel;
   logic sample_switch, converter_power_on, conv_clock_source;
   logic sequence_done_flag, sar_cmp;
   int bad_count = 0, comparisons = 0;
   always #2 clk_sys = ~clk_sys;
   // Slow tick stands in for the free-running R-C oscillator
   always @(posedge clk_sys) begin
      rc_cnt <= rc_cnt + 3'h1;
      rc_clk_tick <= rc_cnt == 3'h0;
   end
   asc_adc_sequence_controller asc_adc_sequence_controller_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .low_power_mode(low_power_mode),
      .rc_clk_tick(rc_clk_tick), .sar_cmp(sar_cmp), .mux_sel(mux_sel),
      .sample_switch(sample_switch), .sar_trial(sar_trial),
      .converter_power_on(converter_power_on),
      .conv_clock_source(conv_clock_source),
      .sequence_done_flag(sequence_done_flag));
   asc_sar_model asc_sar_model_inst (.mux_sel(mux_sel),
      .sar_trial(sar_trial), .sar_cmp(sar_cmp));
   // ============================================================
   // Tasks
   task end_sim;
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, e);
      @(posedge clk_sys);
   endtask
   function automatic logic [7:0] lvl(input logic [3:0] c);
      return c == ASC_CH_VRH ? ASC_CODE_HI : c == ASC_CH_VRL ? ASC_CODE_LO :
         c == ASC_CH_HALF ? ASC_CODE_HALF : {c, ~c};
   endfunction
   task wait_done;
      for (int i = 0; i < 5000 && sequence_done_flag !== 1'b1; i++)
         @(negedge clk_sys);
      chk({7'h00, sequence_done_flag}, 8'h01);
      @(posedge clk_sys);
   endtask
   task res(input logic [3:0] c, input logic grp);
      for (logic [2:0] k = 3'h0; k < 3'h4; k++)
         rd(ASC_OFS_RES1 + k, lvl(grp ? {c[3:2], k[1:0]} : c));
   endtask
   // ============================================================
   // Sequence
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      rd(ASC_OFS_CTRL, ASC_CTRL_RST);
      rd(ASC_OFS_OPT, ASC_OPT_RST);
      rd(3'h6, 8'h00);
      wr(ASC_OFS_OPT, 8'h80);
      wr(ASC_OFS_CTRL, 8'hC3);
      rd(ASC_OFS_CTRL, 8'h03);
      // Write taken at edge 0: old result read at edge 32, new at edge 34
      repeat (28) @(posedge clk_sys);
      rd(ASC_OFS_RES1, ASC_RES_RST);
      rd(ASC_OFS_RES1, lvl(4'h3));
      wait_done;
      rd(ASC_OFS_CTRL, 8'h83);
      res(4'h3, 1'b0);
      wr(ASC_OFS_RES1, 8'h55);
      rd(ASC_OFS_RES1, lvl(4'h3));
      for (g = 3'h0; g < 3'h4; g++) begin
         wr(ASC_OFS_CTRL, {4'h1, g[1:0], 2'h3});
         wait_done;
         res({g[1:0], 2'h0}, 1'b1);
      end
      wr(ASC_OFS_CTRL, 8'h05);
      repeat (60) @(posedge clk_sys);
      wr(ASC_OFS_CTRL, 8'h06);
      rd(ASC_OFS_CTRL, 8'h06);
      wait_done;
      res(4'h6, 1'b0);
      wr(ASC_OFS_CTRL, 8'h09);
      repeat (50) @(posedge clk_sys);
      low_power_mode <= 1'b1;
      repeat (40) @(posedge clk_sys);
      low_power_mode <= 1'b0;
      // The suspended slot is sampled again, so done comes near edge 188
      repeat (88) @(negedge clk_sys);
      chk({7'h00, sequence_done_flag}, 8'h00);
      wait_done;
      res(4'h9, 1'b0);
      wr(ASC_OFS_OPT, 8'hC0);
      wr(ASC_OFS_CTRL, 8'h02);
      // Stepping on the slow tick keeps the sequence far from done here
      repeat (200) @(negedge clk_sys);
      chk({7'h00, sequence_done_flag}, 8'h00);
      wait_done;
      res(4'h2, 1'b0);
      wr(ASC_OFS_OPT, 8'h80);
      wr(ASC_OFS_CTRL, 8'h3C);
      wait_done;
      repeat (300) @(posedge clk_sys);
      rd(ASC_OFS_CTRL, 8'hBC);
      res(4'hC, 1'b1);
      wr(ASC_OFS_CTRL, 8'h27);
      wait_done;
      repeat (300) @(posedge clk_sys);
      rd(ASC_OFS_CTRL, 8'hA7);
      res(4'h7, 1'b0);
      wr(ASC_OFS_OPT, 8'h00);
      wr(ASC_OFS_CTRL, 8'h04);
      repeat (200) @(posedge clk_sys);
      rd(ASC_OFS_CTRL, 8'h04);
      end_sim;
   end
endmodule // tb_adc_sequence_controller
`default_nettype wire
